// ==== shared/dcdl_defines.svh ====
// constants for the dac clock delay loop controller
// Overview of operation
// - power-down bit, reset one, holds loop off
// - fine and coarse duty correction enables, default on
// - fine and coarse cross control enables, default on
// - controller off: delay comes from setpoint only
// - controller on: search/track, track, search modes
// - search direction field and target slope select
// - track and search error behaviour bits
// - read-only fail flag when lock not achieved
// - lost-lock flag, software writable, hardware sets
// - read-only locked flag once lock achieved
// - coarse setpoint: static delay and start point
`ifndef DCDL_DEFINES_SVH
`define DCDL_DEFINES_SVH

// register offsets
`define DCDL_OFS_PWR 12'h090
`define DCDL_OFS_CTRL 12'h091
`define DCDL_OFS_STATUS 12'h092
`define DCDL_OFS_GUARD 12'h093
`define DCDL_OFS_COARSE 12'h094

// power and correction field positions
`define DCDL_BIT_FINE_DC 4
`define DCDL_BIT_FINE_XC 3
`define DCDL_BIT_COARSE_DC 2
`define DCDL_BIT_COARSE_XC 1
`define DCDL_BIT_PD 0

// control field positions
`define DCDL_BIT_TRACK_ERR 7
`define DCDL_BIT_SEARCH_ERR 6
`define DCDL_BIT_SLOPE 5
`define DCDL_MSB_SEARCH 4
`define DCDL_LSB_SEARCH 3
`define DCDL_MSB_MODE 2
`define DCDL_LSB_MODE 1
`define DCDL_BIT_ENABLE 0

// status field positions
`define DCDL_BIT_FAIL 2
`define DCDL_BIT_LOST 1
`define DCDL_BIT_LOCKED 0

// reset values
`define DCDL_RST_PWR 5'h1f
`define DCDL_RST_CTRL 8'hf0
`define DCDL_RST_GUARD 4'h0
`define DCDL_RST_COARSE 6'h00

// timing: settle time after each delay step, least time rounds up
`define DCDL_CLK_PERIOD_PS 25000
`define DCDL_SETTLE_NS 100
`define DCDL_SETTLE_CYC ((`DCDL_SETTLE_NS * 1000 + `DCDL_CLK_PERIOD_PS - 1) / `DCDL_CLK_PERIOD_PS)

`endif

// ==== shared/dcdl_pkg.sv ====
// types for the dac clock delay loop controller
`default_nettype none
package dcdl_pkg;

	// controller states
	typedef enum logic [1:0]
	{
		DCDL_ST_STATIC = 2'b00,
		DCDL_ST_SEARCH = 2'b01,
		DCDL_ST_TRACK = 2'b10,
		DCDL_ST_HOLD = 2'b11
	} dcdl_state_e;

	// controller modes
	typedef enum logic [1:0]
	{
		DCDL_MODE_SEARCH_TRACK = 2'b00,
		DCDL_MODE_TRACK = 2'b01,
		DCDL_MODE_SEARCH = 2'b10,
		DCDL_MODE_RSVD = 2'b11
	} dcdl_mode_e;

	// search directions
	typedef enum logic [1:0]
	{
		DCDL_DIR_DOWN = 2'b00,
		DCDL_DIR_UP = 2'b01,
		DCDL_DIR_BOTH = 2'b10,
		DCDL_DIR_BOTH_ALT = 2'b11
	} dcdl_dir_e;

endpackage
`default_nettype wire

// ==== logic/dcdl_phase_sync.sv ====
// phase detector input synchroniser with three-sample majority filter
`timescale 1ns/1ps
`default_nettype none
module dcdl_phase_sync
(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// raw comparator level from the analog phase detector
	input wire logic phase_raw,
	// filtered, synchronised level
	output logic phase_filt
);

	logic sync_a;
	logic sync_b;
	logic [2:0] hist;
	logic majority;

	// two flops before anything reads the pin
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end
		else
		begin
			sync_a <= phase_raw;
			sync_b <= sync_a;
		end
	end

	// majority vote hides comparator chatter near the crossing
	assign majority = (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hist <= 3'h0;
			phase_filt <= 1'b0;
		end
		else
		begin
			hist <= {hist[1:0], sync_b};
			phase_filt <= majority;
		end
	end

endmodule // dcdl_phase_sync
`default_nettype wire

// ==== logic/dcdl_loop_ctrl.sv ====
// delay loop controller: register file, search and track engine
`timescale 1ns/1ps
`default_nettype none
`include "dcdl_defines.svh"
module dcdl_loop_ctrl
#(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned COARSE_W = 6,
	parameter int unsigned SETTLE_CYC = `DCDL_SETTLE_CYC
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port from the serial control interface
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// phase detector comparator, asynchronous
	input wire logic phase_late,
	// analog controls
	output logic loop_clock_powerdown,
	output logic fine_duty_correct_en,
	output logic fine_cross_ctrl_en,
	output logic coarse_duty_correct_en,
	output logic coarse_cross_ctrl_en,
	output logic [COARSE_W-1:0] coarse_delay,
	// status
	output logic lock_achieved_flag,
	output logic lock_lost_flag,
	output logic lock_fail_flag
);

	localparam logic [COARSE_W-1:0] DLY_MAX = {COARSE_W{1'b1}};
	localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

	// one delay step with range check: {limit hit, next value}
	function automatic logic [COARSE_W:0] step_delay(input logic [COARSE_W-1:0] cur,
		input logic up, input logic [COARSE_W-1:0] lo, input logic [COARSE_W-1:0] hi);
		logic [COARSE_W:0] res;
		res = {1'b0, cur};
		if (up)
		begin
			if (cur >= hi)
				res = {1'b1, cur};
			else
				res = {1'b0, COARSE_W'(cur + 1'b1)};
		end
		else
		begin
			if (cur <= lo)
				res = {1'b1, cur};
			else
				res = {1'b0, COARSE_W'(cur - 1'b1)};
		end
		return res;
	endfunction

	// software registers
	logic [4:0] pwr_reg;
	logic [7:0] ctrl_reg;
	logic [3:0] guard_reg;
	logic [COARSE_W-1:0] setpoint;

	// controller state
	dcdl_pkg::dcdl_state_e state;
	dcdl_pkg::dcdl_state_e next_state;
	logic [COARSE_W-1:0] cur;
	logic [COARSE_W-1:0] next_cur;
	logic dir_up;
	logic next_dir_up;
	logic second_leg;
	logic next_second_leg;
	logic prev_want;
	logic next_prev_want;
	logic have_prev;
	logic next_have_prev;
	logic [7:0] settle_cnt;
	logic [7:0] next_settle_cnt;
	logic set_locked;
	logic clr_locked;
	logic set_lost;
	logic set_fail;
	logic clr_fail;

	// filtered phase level
	logic phase_s;

	dcdl_phase_sync u_sync
	(
		.mclk(mclk),
		.arst_n(arst_n),
		.phase_raw(phase_late),
		.phase_filt(phase_s)
	);

	// address decode
	wire hit_pwr = (reg_addr == ADDR_W'(`DCDL_OFS_PWR));
	wire hit_ctrl = (reg_addr == ADDR_W'(`DCDL_OFS_CTRL));
	wire hit_status = (reg_addr == ADDR_W'(`DCDL_OFS_STATUS));
	wire hit_guard = (reg_addr == ADDR_W'(`DCDL_OFS_GUARD));
	wire hit_coarse = (reg_addr == ADDR_W'(`DCDL_OFS_COARSE));

	// control field views
	wire powered_down = pwr_reg[`DCDL_BIT_PD];
	wire loop_enable = ctrl_reg[`DCDL_BIT_ENABLE];
	wire slope_pos = ctrl_reg[`DCDL_BIT_SLOPE];
	wire track_stop = ctrl_reg[`DCDL_BIT_TRACK_ERR];
	wire search_retry = ctrl_reg[`DCDL_BIT_SEARCH_ERR];
	wire [1:0] mode_bits = ctrl_reg[`DCDL_MSB_MODE:`DCDL_LSB_MODE];
	wire [1:0] dir_bits = ctrl_reg[`DCDL_MSB_SEARCH:`DCDL_LSB_SEARCH];
	wire run_loop = loop_enable & ~powered_down;
	wire search_only = (mode_bits == dcdl_pkg::DCDL_MODE_SEARCH);
	wire track_only = (mode_bits == dcdl_pkg::DCDL_MODE_TRACK);
	wire dir_both = dir_bits[1];
	wire dir_start_up = dir_bits[1] | dir_bits[0];

	// search bounds kept off the delay-line ends by the guard band
	wire [COARSE_W-1:0] lo_bound = COARSE_W'(guard_reg);
	wire [COARSE_W-1:0] hi_bound = DLY_MAX - COARSE_W'(guard_reg);

	// positive slope: detector low below the target, so step up
	wire want_up = phase_s ^ slope_pos;
	wire tick = (settle_cnt == 8'h00);
	wire crossing = have_prev & (want_up != prev_want);
	wire [COARSE_W:0] search_step = step_delay(cur, dir_up, lo_bound, hi_bound);
	wire [COARSE_W:0] track_step = step_delay(cur, want_up, {COARSE_W{1'b0}}, DLY_MAX);

	// readback selection, reserved bits read zero
	wire [7:0] status_view = {5'h00, lock_fail_flag, lock_lost_flag, lock_achieved_flag};
	wire [7:0] rd_mux = hit_pwr ? {3'h0, pwr_reg} :
		hit_ctrl ? ctrl_reg :
		hit_status ? status_view :
		hit_guard ? {4'h0, guard_reg} :
		hit_coarse ? 8'(setpoint) :
		8'h00;

	// software register writes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pwr_reg <= `DCDL_RST_PWR;
			ctrl_reg <= `DCDL_RST_CTRL;
			guard_reg <= `DCDL_RST_GUARD;
			setpoint <= COARSE_W'(`DCDL_RST_COARSE);
		end
		else if (reg_wr)
		begin
			if (hit_pwr)
				pwr_reg <= reg_wdata[4:0];
			else if (hit_ctrl)
				ctrl_reg <= reg_wdata;
			else if (hit_guard)
				guard_reg <= reg_wdata[3:0];
			else if (hit_coarse)
				setpoint <= reg_wdata[COARSE_W-1:0];
		end
	end

	// read data registered one cycle after the strobe
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

	// search and track engine, next-state logic
	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_dir_up = dir_up;
		next_second_leg = second_leg;
		next_prev_want = prev_want;
		next_have_prev = have_prev;
		next_settle_cnt = tick ? SETTLE_LOAD : settle_cnt - 8'h01;
		set_locked = 1'b0;
		clr_locked = 1'b0;
		set_lost = 1'b0;
		set_fail = 1'b0;
		clr_fail = 1'b0;
		if (!run_loop)
		begin
			// static setpoints; no feedback while disabled or powered down
			next_state = dcdl_pkg::DCDL_ST_STATIC;
			next_cur = setpoint;
			clr_locked = 1'b1;
			next_settle_cnt = SETTLE_LOAD;
		end
		else
		begin
			case (state)
				dcdl_pkg::DCDL_ST_STATIC:
				begin
					// start from the software setpoint
					next_cur = setpoint;
					next_dir_up = dir_start_up;
					next_second_leg = 1'b0;
					next_have_prev = 1'b0;
					clr_fail = 1'b1;
					next_state = track_only ? dcdl_pkg::DCDL_ST_TRACK :
						dcdl_pkg::DCDL_ST_SEARCH;
				end
				dcdl_pkg::DCDL_ST_SEARCH:
				begin
					if (tick)
					begin
						if (crossing)
						begin
							// target edge found: lock here
							set_locked = 1'b1;
							next_have_prev = 1'b0;
							next_state = search_only ? dcdl_pkg::DCDL_ST_HOLD :
								dcdl_pkg::DCDL_ST_TRACK;
						end
						else if (!search_step[COARSE_W])
						begin
							next_cur = search_step[COARSE_W-1:0];
							next_prev_want = want_up;
							next_have_prev = 1'b1;
						end
						else if (dir_both && !second_leg)
						begin
							// first leg exhausted: reverse from the start point
							next_cur = setpoint;
							next_dir_up = ~dir_up;
							next_second_leg = 1'b1;
							next_have_prev = 1'b0;
						end
						else
						begin
							// search error: flag, then stop or start over
							set_fail = 1'b1;
							next_have_prev = 1'b0;
							next_cur = setpoint;
							next_dir_up = dir_start_up;
							next_second_leg = 1'b0;
							if (!search_retry)
								next_state = dcdl_pkg::DCDL_ST_HOLD;
						end
					end
				end
				dcdl_pkg::DCDL_ST_TRACK:
				begin
					if (tick)
					begin
						// track only mode locks on its first crossing
						if (crossing && !lock_achieved_flag)
							set_locked = 1'b1;
						next_prev_want = want_up;
						next_have_prev = 1'b1;
						if (!track_step[COARSE_W])
							next_cur = track_step[COARSE_W-1:0];
						else
						begin
							// line end reached: lock is gone
							clr_locked = 1'b1;
							set_lost = lock_achieved_flag;
							if (track_stop)
								next_state = dcdl_pkg::DCDL_ST_HOLD;
						end
					end
				end
				default:
				begin
					// hold last delay until software disables the loop
					next_state = dcdl_pkg::DCDL_ST_HOLD;
				end
			endcase
		end
	end

	// engine state registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= dcdl_pkg::DCDL_ST_STATIC;
			cur <= COARSE_W'(`DCDL_RST_COARSE);
			dir_up <= 1'b1;
			second_leg <= 1'b0;
			prev_want <= 1'b0;
			have_prev <= 1'b0;
			settle_cnt <= 8'h00;
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			dir_up <= next_dir_up;
			second_leg <= next_second_leg;
			prev_want <= next_prev_want;
			have_prev <= next_have_prev;
			settle_cnt <= next_settle_cnt;
		end
	end

	// status flags; a hardware set wins over a software write
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lock_achieved_flag <= 1'b0;
			lock_lost_flag <= 1'b0;
			lock_fail_flag <= 1'b0;
		end
		else
		begin
			if (set_locked)
				lock_achieved_flag <= 1'b1;
			else if (clr_locked)
				lock_achieved_flag <= 1'b0;
			if (set_lost)
				lock_lost_flag <= 1'b1;
			else if (reg_wr && hit_status)
				lock_lost_flag <= reg_wdata[`DCDL_BIT_LOST];
			if (set_fail)
				lock_fail_flag <= 1'b1;
			else if (clr_fail)
				lock_fail_flag <= 1'b0;
		end
	end

	// analog control outputs, all registered
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			loop_clock_powerdown <= 1'b1;
			fine_duty_correct_en <= 1'b1;
			fine_cross_ctrl_en <= 1'b1;
			coarse_duty_correct_en <= 1'b1;
			coarse_cross_ctrl_en <= 1'b1;
			coarse_delay <= COARSE_W'(`DCDL_RST_COARSE);
		end
		else
		begin
			loop_clock_powerdown <= powered_down;
			fine_duty_correct_en <= pwr_reg[`DCDL_BIT_FINE_DC];
			coarse_duty_correct_en <= pwr_reg[`DCDL_BIT_COARSE_DC];
			fine_cross_ctrl_en <= pwr_reg[`DCDL_BIT_FINE_XC];
			coarse_cross_ctrl_en <= pwr_reg[`DCDL_BIT_COARSE_XC];
			coarse_delay <= (state == dcdl_pkg::DCDL_ST_STATIC) ? setpoint : cur;
		end
	end

endmodule // dcdl_loop_ctrl
`default_nettype wire

// ==== tb/dcdl_loop_ctrl_sva.sv ====
// port checker for the delay loop controller
`timescale 1ns/1ps
`default_nettype none
module dcdl_loop_ctrl_sva
#(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned COARSE_W = 6,
	parameter int unsigned SETTLE_CYC = 4
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// loop controls and status
	input wire logic phase_late,
	input wire logic loop_clock_powerdown,
	input wire logic fine_duty_correct_en,
	input wire logic fine_cross_ctrl_en,
	input wire logic coarse_duty_correct_en,
	input wire logic coarse_cross_ctrl_en,
	input wire logic [COARSE_W-1:0] coarse_delay,
	input wire logic lock_achieved_flag,
	input wire logic lock_lost_flag,
	input wire logic lock_fail_flag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// strobes decoded per register
	wire logic w_pwr = reg_wr && reg_addr == 12'h090;
	wire logic w_ctl = reg_wr && reg_addr == 12'h091;
	wire logic w_sts = reg_wr && reg_addr == 12'h092;
	wire logic w_crs = reg_wr && reg_addr == 12'h094;
	wire logic r_ctl = reg_rd && reg_addr == 12'h091;
	wire logic r_sts = reg_rd && reg_addr == 12'h092;

	// register then output flop: the pins follow a write two edges later
	pd_write_a: assert property (w_pwr |-> ##2 loop_clock_powerdown == $past(reg_wdata[0], 2))
		else $error("power-down output differs from write");
	corr_write_a: assert property (w_pwr |-> ##2 {fine_duty_correct_en, fine_cross_ctrl_en,
		coarse_duty_correct_en, coarse_cross_ctrl_en} == $past(reg_wdata[4:1], 2))
		else $error("correction enables differ from write");
	// pd pin lags its bit, so a power-up write just before would let the loop start
	static_delay_a: assert property ((w_crs && loop_clock_powerdown && !$past(w_pwr)) ##1 !reg_wr
		|=> coarse_delay == $past(reg_wdata[COARSE_W-1:0], 2)) else $error("static delay wrong");
	ctrl_read_a: assert property (w_ctl ##1 (r_ctl && !reg_wr)
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("control readback wrong");
	status_read_a: assert property (r_sts |=> reg_rdata == {5'h00, $past(lock_fail_flag),
		$past(lock_lost_flag), $past(lock_achieved_flag)}) else $error("status readback wrong");
	lost_write_a: assert property (w_sts && loop_clock_powerdown
		|=> lock_lost_flag == $past(reg_wdata[1])) else $error("lost flag ignores write");
	flags_ro_a: assert property ((w_sts && loop_clock_powerdown && $past(loop_clock_powerdown)
		&& !$past(w_pwr))
		|=> $stable(lock_fail_flag) && $stable(lock_achieved_flag))
		else $error("read-only flag changed by write");
	lock_power_a: assert property ($rose(lock_achieved_flag) |-> !$past(loop_clock_powerdown))
		else $error("lock while powered down");
	fail_power_a: assert property ($rose(lock_fail_flag) |-> !$past(loop_clock_powerdown))
		else $error("fail while powered down");

	// main scenarios reached
	cover property (w_pwr);
	cover property ($rose(lock_achieved_flag));
	cover property ($rose(lock_lost_flag));
	cover property ($rose(lock_fail_flag));
endmodule // dcdl_loop_ctrl_sva

bind dcdl_loop_ctrl dcdl_loop_ctrl_sva #(.ADDR_W(ADDR_W), .COARSE_W(COARSE_W),
	.SETTLE_CYC(SETTLE_CYC)) u_sva (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .phase_late, .loop_clock_powerdown, .fine_duty_correct_en, .fine_cross_ctrl_en,
	.coarse_duty_correct_en, .coarse_cross_ctrl_en, .coarse_delay, .lock_achieved_flag,
	.lock_lost_flag, .lock_fail_flag);
`default_nettype wire

// ==== tb/dcdl_loop_ctrl_tb.sv ====
// self-checking bench for the delay loop controller
`timescale 1ns/1ps
`default_nettype none
module dcdl_loop_ctrl_tb;
	// design signals
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic phase_late = 1'b0;
	logic [7:0] reg_rdata;
	logic loop_clock_powerdown, fine_duty_correct_en, fine_cross_ctrl_en;
	logic coarse_duty_correct_en, coarse_cross_ctrl_en;
	logic [5:0] coarse_delay;
	logic lock_achieved_flag, lock_lost_flag, lock_fail_flag;
	int bad_count = 0;
	int check_count = 0;
	int seed = 32'heb15;
	logic [11:0] a;
	logic [7:0] d;
	logic [5:0] low = 6'h3f;
	wire logic [2:0] flags = {lock_fail_flag, lock_lost_flag, lock_achieved_flag};
	wire logic [7:0] ctl_out = {3'h0, fine_duty_correct_en, fine_cross_ctrl_en,
		coarse_duty_correct_en, coarse_cross_ctrl_en, loop_clock_powerdown};

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	dcdl_loop_ctrl #(.SETTLE_CYC(4)) dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .phase_late, .loop_clock_powerdown, .fine_duty_correct_en,
		.fine_cross_ctrl_en, .coarse_duty_correct_en, .coarse_cross_ctrl_en, .coarse_delay,
		.lock_achieved_flag, .lock_lost_flag, .lock_fail_flag);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one register cycle per call, entered at a falling edge; strobes stay until the next call
	task automatic acc(input logic w, input logic r, input logic [11:0] ad, input logic [7:0] dt);
		reg_wr = w;
		reg_rd = r;
		reg_addr = ad;
		reg_wdata = dt;
		@(negedge mclk);
	endtask

	task automatic rdchk(input logic [11:0] ad, input logic [7:0] exp);
		acc(1'b0, 1'b1, ad, 8'h00);
		chk(reg_rdata, exp);
	endtask

	// bounded wait on one status flag, bus idle meanwhile
	task automatic await(input int k, input int lim);
		acc(1'b0, 1'b0, 12'h000, 8'h00);
		for (int i = 0; i < lim && flags[k] !== 1'b1; i++)
		begin
			@(negedge mclk);
			// lowest delay seen, for the guard band check
			if (coarse_delay < low)
				low = coarse_delay;
		end
	endtask

	// readback expected from the writable bits of each register except status
	function automatic logic [7:0] mask(input logic [11:0] ad, input logic [7:0] dt);
		case (ad)
			12'h090: mask = dt & 8'h1f;
			12'h091: mask = dt;
			12'h093: mask = dt & 8'h0f;
			12'h094: mask = dt & 8'h3f;
			default: mask = 8'h00;
		endcase
	endfunction

	// restart the loop from setpoint 0x20, then flip the phase to force a crossing
	task automatic run_lock(input logic [1:0] m, input logic [1:0] dir);
		// synchroniser and filter need five edges; a stale high level would fake a crossing
		phase_late = 1'b0;
		acc(1'b1, 1'b0, 12'h091, 8'h20);
		acc(1'b1, 1'b0, 12'h094, 8'h20);
		acc(1'b1, 1'b0, 12'h091, {3'b001, dir, m, 1'b1});
		await(0, 30);
		chk({7'h0, lock_achieved_flag}, 8'h00);
		chk({7'h0, coarse_delay > 6'h20}, {7'h0, dir != 2'b00});
		phase_late = 1'b1;
		await(0, 100);
		chk({7'h0, lock_achieved_flag}, 8'h01);
		$display("lock run mode %h dir %h done", m, dir);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// watchdog against a hung wait
	initial
	begin
		#(25 * 6000);
		bad_count++;
		complete_run();
	end

	// main sequence
	initial
	begin
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		chk(ctl_out, 8'h1f);
		chk({5'h0, flags}, 8'h00);
		chk({2'h0, coarse_delay}, 8'h00);
		rdchk(12'h090, 8'h1f);
		rdchk(12'h091, 8'hf0);
		rdchk(12'h092, 8'h00);
		rdchk(12'h093, 8'h00);
		rdchk(12'h094, 8'h00);
		rdchk(12'h08f, 8'h00);
		rdchk(12'h095, 8'h00);
		rdchk(12'h190, 8'h00);
		acc(1'b1, 1'b0, 12'h092, 8'hff);
		rdchk(12'h092, 8'h02);
		acc(1'b1, 1'b0, 12'h092, 8'h00);
		rdchk(12'h092, 8'h00);
		$display("reset and status test done");
		for (int i = 0; i < 24; i++)
		begin
			a = 12'h090 + {10'h0, $random(seed) % 2 ? 2'd0 : 2'd1} + (i % 2 ? 12'h3 : 12'h0);
			d = $random(seed);
			acc(1'b1, 1'b0, a, d);
			rdchk(a, mask(a, d));
			if (a == 12'h090)
				chk(ctl_out, d & 8'h1f);
		end
		$display("random register test done");
		acc(1'b1, 1'b0, 12'h091, 8'h20);
		acc(1'b1, 1'b0, 12'h093, 8'h00);
		acc(1'b1, 1'b0, 12'h090, 8'h00);
		acc(1'b1, 1'b0, 12'h094, 8'h2a);
		await(0, 3);
		chk({2'h0, coarse_delay}, 8'h2a);
		$display("static delay test done");
		for (int i = 0; i < 3; i++)
			run_lock(i[1:0], i[1:0]);
		run_lock(2'b00, 2'b00);
		await(1, 400);
		chk({5'h0, flags}, 8'h02);
		chk({2'h0, coarse_delay}, 8'h00);
		$display("track error test done");
		phase_late = 1'b0;
		acc(1'b1, 1'b0, 12'h091, 8'h20);
		acc(1'b1, 1'b0, 12'h092, 8'h00);
		acc(1'b1, 1'b0, 12'h093, 8'h02);
		acc(1'b1, 1'b0, 12'h094, 8'h04);
		low = 6'h3f;
		acc(1'b1, 1'b0, 12'h091, 8'h25);
		await(2, 200);
		await(0, 20);
		rdchk(12'h092, 8'h04);
		chk({2'h0, low}, 8'h02);
		chk({2'h0, coarse_delay}, 8'h04);
		$display("search error test done");
		complete_run();
	end
endmodule // dcdl_loop_ctrl_tb
`default_nettype wire
